/* File: rtl/tx_fault_supervisor_consts.vh */
// Constants for the transmitter fault supervisor.
// Assumes inclusion by bare name from files under rtl/.
`ifndef TX_FAULT_SUPERVISOR_CONSTS_VH
`define TX_FAULT_SUPERVISOR_CONSTS_VH

// Converter codes: full scale 4095. Defaults chosen for a 7.0 V / 4.0 A span.
`define OV_LIMIT_RST 12'he86
`define OC_LIMIT_RST 12'h7ff
`define TEMP_LIMIT_RST 12'hc00
`define TEMP_CLEAR_RST 12'ha00
`define ADC_BITS 12
`define CH_VIN 4'h0
`define CH_ISENSE 4'h1
`define CH_REFERENCE 4'h8
`define CH_DIE_TEMP 4'h9
// Ping interval 10 ms, startup window 100 us, buzzer 100 ms.
`define PING_NS 10000000
`define STARTUP_NS 100000
`define BUZZ_NS 100000000
`define CLK_NS 8
`define LEVEL_BITS 8
`define LEVEL_RST 8'h40

`endif

/* File: rtl/adc_sequencer.v */
// Scans the converter multiplexer over supply, current, reference and die
// temperature, and holds the last result of each.
// Assumes a converter that answers each start with one done pulse.
`include "tx_fault_supervisor_consts.vh"

module adc_sequencer (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_adc_done,
    input wire [`ADC_BITS-1:0] i_adc_data,
    output reg o_adc_start,
    output reg [3:0] o_adc_channel,
    output reg [`ADC_BITS-1:0] o_vin_code,
    output reg [`ADC_BITS-1:0] o_isense_code,
    output reg [`ADC_BITS-1:0] o_reference_channel,
    output reg [`ADC_BITS-1:0] o_die_temp_channel,
    output reg o_vin_valid,
    output reg o_isense_valid,
    output reg o_temp_valid
);
    reg [1:0] slot_reg;
    reg busy_reg;

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            slot_reg <= 2'h0;
            busy_reg <= 1'b0;
            o_adc_start <= 1'b0;
            o_adc_channel <= `CH_VIN;
            o_vin_code <= 12'h000;
            o_isense_code <= 12'h000;
            o_reference_channel <= 12'h000;
            o_die_temp_channel <= 12'h000;
            o_vin_valid <= 1'b0;
            o_isense_valid <= 1'b0;
            o_temp_valid <= 1'b0;
        end else begin
            o_adc_start <= 1'b0;
            o_vin_valid <= 1'b0;
            o_isense_valid <= 1'b0;
            o_temp_valid <= 1'b0;
            if (!busy_reg) begin
                busy_reg <= 1'b1;
                o_adc_start <= 1'b1;
                case (slot_reg)
                    2'h0: o_adc_channel <= `CH_VIN;
                    2'h1: o_adc_channel <= `CH_ISENSE;
                    2'h2: o_adc_channel <= `CH_REFERENCE;
                    default: o_adc_channel <= `CH_DIE_TEMP;
                endcase
            end else if (i_adc_done) begin
                busy_reg <= 1'b0;
                slot_reg <= slot_reg + 2'h1;
                case (slot_reg)
                    2'h0: begin
                        o_vin_code <= i_adc_data;
                        o_vin_valid <= 1'b1;
                    end
                    2'h1: begin
                        o_isense_code <= i_adc_data;
                        o_isense_valid <= 1'b1;
                    end
                    2'h2: o_reference_channel <= i_adc_data;
                    default: begin
                        o_die_temp_channel <= i_adc_data;
                        o_temp_valid <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // adc_sequencer

/* File: rtl/tx_fault_supervisor.v */
// Fault supervisor and power-state sequencer of the transmitter.
// Assumes a 12-bit converter behind a multiplexer, a detector that reports
// ping results, and a demodulator giving one pulse per receiver request.
// How it works
// - Supply over-voltage checked only in startup window.
// - Sense current compared against limit every sample.
// - Both limits are programmable inputs, not constants.
// - Over-current stops power and latches fault.
// - Over-current latch clears by replacement or reset.
// - Startup over-voltage blocks operation until power cycle.
// - Over-temperature shuts power down until cooled.
// - Idle state sleeps and pings periodically.
// - Negotiation then transfer only after valid detection.
// - Receiver up/down/hold requests adjust power level.
// - Buzzer pulses when transfer link is established.
// - Channel eight reference, nine die temperature.
`include "tx_fault_supervisor_consts.vh"

module tx_fault_supervisor #(
    parameter PING_CYCLES = (`PING_NS + `CLK_NS - 1) / `CLK_NS,
    parameter STARTUP_CYCLES = (`STARTUP_NS + `CLK_NS - 1) / `CLK_NS,
    parameter BUZZ_CYCLES = `BUZZ_NS / `CLK_NS
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [`ADC_BITS-1:0] i_ov_limit,
    input wire [`ADC_BITS-1:0] i_oc_limit,
    input wire i_adc_done,
    input wire [`ADC_BITS-1:0] i_adc_data,
    input wire i_detect_done,
    input wire i_detect_valid,
    input wire i_negotiate_done,
    input wire i_negotiate_fail,
    input wire i_req_valid,
    input wire [1:0] i_req_code,
    output wire o_adc_start,
    output wire [3:0] o_adc_channel,
    output reg o_ping,
    output reg o_power_enable,
    output reg [`LEVEL_BITS-1:0] o_power_level,
    output reg o_sleep,
    output reg o_link_up,
    output reg o_buzzer,
    output reg o_overvoltage_guard,
    output reg o_overcurrent_guard,
    output reg o_thermal_shutdown,
    output reg [2:0] o_state,
    output wire [`ADC_BITS-1:0] o_reference_channel,
    output wire [`ADC_BITS-1:0] o_die_temp_channel
);
    localparam [2:0] ST_STARTUP = 3'h0;
    localparam [2:0] ST_SLEEP = 3'h1;
    localparam [2:0] ST_PING = 3'h2;
    localparam [2:0] ST_NEGOTIATE = 3'h3;
    localparam [2:0] ST_TRANSFER = 3'h4;
    localparam [2:0] ST_HALT = 3'h5;
    localparam [1:0] REQ_HOLD = 2'h0;
    localparam [1:0] REQ_UP = 2'h1;
    localparam [1:0] REQ_DOWN = 2'h2;

    wire [`ADC_BITS-1:0] vin_code;
    wire [`ADC_BITS-1:0] isense_code;
    wire vin_valid;
    wire isense_valid;
    wire temp_valid;
    wire over_current;
    wire over_temp;
    wire cool;
    reg [31:0] timer_reg;
    reg [31:0] buzz_reg;
    reg missed_reg;

    adc_sequencer u_adc (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_adc_done(i_adc_done),
        .i_adc_data(i_adc_data),
        .o_adc_start(o_adc_start),
        .o_adc_channel(o_adc_channel),
        .o_vin_code(vin_code),
        .o_isense_code(isense_code),
        .o_reference_channel(o_reference_channel),
        .o_die_temp_channel(o_die_temp_channel),
        .o_vin_valid(vin_valid),
        .o_isense_valid(isense_valid),
        .o_temp_valid(temp_valid)
    );

    // The current limit comes from the surrounding configuration, so it can be tuned; the temperature limits are fixed constants.
    assign over_current = isense_valid && (isense_code > i_oc_limit);
    assign over_temp = temp_valid &&
        (o_die_temp_channel > `TEMP_LIMIT_RST);
    // Hysteresis keeps the stage from chattering around the trip point.
    assign cool = temp_valid && (o_die_temp_channel < `TEMP_CLEAR_RST);

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_state <= ST_STARTUP;
            timer_reg <= 32'h0;
            buzz_reg <= 32'h0;
            missed_reg <= 1'b0;
            o_ping <= 1'b0;
            o_power_enable <= 1'b0;
            o_power_level <= `LEVEL_RST;
            o_sleep <= 1'b0;
            o_link_up <= 1'b0;
            o_buzzer <= 1'b0;
            o_overvoltage_guard <= 1'b0;
            o_overcurrent_guard <= 1'b0;
            o_thermal_shutdown <= 1'b0;
        end else begin
            o_ping <= 1'b0;
            if (buzz_reg != 32'h0) begin
                buzz_reg <= buzz_reg - 32'h1;
            end
            o_buzzer <= (buzz_reg > 32'h1);
            // Shutdown is chosen over self-reset so the fault stays visible.
            if (over_temp) begin
                o_thermal_shutdown <= 1'b1;
            end else if (cool) begin
                o_thermal_shutdown <= 1'b0;
            end
            case (o_state)
                ST_STARTUP: begin
                    // Supply is judged only inside this window, never later.
                    timer_reg <= timer_reg + 32'h1;
                    if (vin_valid && vin_code > i_ov_limit) begin
                        o_overvoltage_guard <= 1'b1;
                        o_state <= ST_HALT;
                    end else if (timer_reg >= STARTUP_CYCLES - 1) begin
                        timer_reg <= 32'h0;
                        o_state <= ST_SLEEP;
                        o_sleep <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    // Thermal trip parks the stage in sleep with no pings.
                    if (!o_thermal_shutdown) begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                    if (timer_reg >= PING_CYCLES - 1) begin
                        timer_reg <= 32'h0;
                        o_ping <= 1'b1;
                        o_sleep <= 1'b0;
                        o_state <= ST_PING;
                    end
                end
                ST_PING: begin
                    if (i_detect_done) begin
                        if (i_detect_valid) begin
                            if (missed_reg) begin
                                o_overcurrent_guard <= 1'b0;
                            end
                            missed_reg <= 1'b0;
                            if (!o_overcurrent_guard || missed_reg) begin
                                o_state <= ST_NEGOTIATE;
                            end else begin
                                o_state <= ST_SLEEP;
                                o_sleep <= 1'b1;
                            end
                        end else begin
                            // A failed detection means the receiver was lifted
                            // away; the next valid one means it is back.
                            missed_reg <= 1'b1;
                            o_state <= ST_SLEEP;
                            o_sleep <= 1'b1;
                        end
                    end
                end
                ST_NEGOTIATE: begin
                    if (i_negotiate_fail) begin
                        o_state <= ST_SLEEP;
                        o_sleep <= 1'b1;
                    end else if (i_negotiate_done) begin
                        o_state <= ST_TRANSFER;
                        o_power_enable <= 1'b1;
                        o_power_level <= `LEVEL_RST;
                        o_link_up <= 1'b1;
                        buzz_reg <= BUZZ_CYCLES + 1;
                    end
                end
                ST_TRANSFER: begin
                    if (i_req_valid) begin
                        case (i_req_code)
                            REQ_UP: if (o_power_level != 8'hff)
                                o_power_level <= o_power_level + 8'h01;
                            REQ_DOWN: if (o_power_level != 8'h00)
                                o_power_level <= o_power_level - 8'h01;
                            // Hold and the spare code leave the level alone.
                            REQ_HOLD: o_power_level <= o_power_level;
                            default: o_power_level <= o_power_level;
                        endcase
                    end
                end
                // Only a power cycle, seen as reset, leaves the halt state.
                ST_HALT: o_state <= ST_HALT;
                default: o_state <= ST_SLEEP;
            endcase
            // In negotiate and transfer, protection overrides any sequencing decision made above.
            if (o_state == ST_TRANSFER || o_state == ST_NEGOTIATE) begin
                if (over_current || over_temp) begin
                    if (over_current) begin
                        o_overcurrent_guard <= 1'b1;
                    end
                    o_power_enable <= 1'b0;
                    o_link_up <= 1'b0;
                    o_state <= ST_SLEEP;
                    o_sleep <= 1'b1;
                    timer_reg <= 32'h0;
                    missed_reg <= 1'b0;
                    // A link cut while still negotiating was never
                    // established, so its pending buzz is dropped.
                    if (o_state == ST_NEGOTIATE) begin
                        buzz_reg <= 32'h0;
                    end
                end
            end
        end
    end
endmodule // tx_fault_supervisor

/* File: verif/tx_fault_supervisor_assertions.sv */
// Port checker for the fault supervisor, bound below.
// Assumes a buzzer count shortened to no less than eight cycles.
module tx_fault_supervisor_assertions (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_adc_done,
    input wire i_detect_done,
    input wire i_detect_valid,
    input wire i_req_valid,
    input wire o_ping,
    input wire o_power_enable,
    input wire o_link_up,
    input wire o_buzzer,
    input wire o_overvoltage_guard,
    input wire o_overcurrent_guard,
    input wire [11:0] i_oc_limit,
    input wire [11:0] i_adc_data,
    input wire [1:0] i_req_code,
    input wire [3:0] o_adc_channel,
    input wire [7:0] o_power_level,
    input wire [2:0] o_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    property p_ovs; $rose(o_overvoltage_guard) |-> $past(o_state) == 3'h0;
    endproperty
    a_ovs: assert property (p_ovs) else $error("late ov trip");
    property p_oc; o_state == 3'h4 && i_adc_done && o_adc_channel == 4'h1
        && i_adc_data > i_oc_limit |-> ##2 o_overcurrent_guard
        && !o_power_enable;
    endproperty
    a_oc: assert property (p_oc) else $error("oc not latched");
    property p_och;
        o_overcurrent_guard && !i_detect_done |=> o_overcurrent_guard;
    endproperty
    a_och: assert property (p_och) else $error("oc latch lost");
    property p_ping; o_ping |-> $past(o_state) == 3'h1; endproperty
    a_ping: assert property (p_ping) else $error("stray ping");
    property p_neg; o_state == 3'h3 && $past(o_state) != 3'h3
        |-> $past(i_detect_done) && $past(i_detect_valid); endproperty
    a_neg: assert property (p_neg) else $error("no valid detect");
    property p_up; o_state == 3'h4 && i_req_valid && i_req_code == 2'h1
        && !i_adc_done && o_power_level != 8'hff
        |=> o_power_level == $past(o_power_level) + 8'h01; endproperty
    a_up: assert property (p_up) else $error("no step up");
    property p_buzz; $rose(o_link_up) |=> o_buzzer [*8]; endproperty
    a_buzz: assert property (p_buzz) else $error("buzzer short");
    property p_halt; o_overvoltage_guard
        |=> o_overvoltage_guard && o_state == 3'h5; endproperty
    a_halt: assert property (p_halt) else $error("ov halt left");
endmodule // tx_fault_supervisor_assertions

bind tx_fault_supervisor tx_fault_supervisor_assertions u_chk (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_adc_done(i_adc_done),
    .i_detect_done(i_detect_done),
    .i_detect_valid(i_detect_valid),
    .i_req_valid(i_req_valid),
    .o_ping(o_ping),
    .o_power_enable(o_power_enable),
    .o_link_up(o_link_up),
    .o_buzzer(o_buzzer),
    .o_overvoltage_guard(o_overvoltage_guard),
    .o_overcurrent_guard(o_overcurrent_guard),
    .i_oc_limit(i_oc_limit),
    .i_adc_data(i_adc_data),
    .i_req_code(i_req_code),
    .o_adc_channel(o_adc_channel),
    .o_power_level(o_power_level),
    .o_state(o_state)
);

/* File: verif/rx_model.sv */
// Receiver and converter stand-in facing the fault supervisor.
// Assumes the bench sets presence, negotiation outcome and samples.
module rx_model #(parameter logic [11:0] REF_CODE = 12'h4b0) (
    input wire i_mclk,
    input wire i_rst,
    input wire i_present,
    input wire i_neg_ok,
    input wire i_adc_start,
    input wire i_ping,
    input wire [11:0] i_vin,
    input wire [11:0] i_isense,
    input wire [11:0] i_temp,
    input wire [3:0] i_adc_channel,
    output logic o_adc_done = 1'b0,
    output logic o_det_done = 1'b0,
    output logic o_det_valid = 1'b0,
    output logic o_neg_done = 1'b0,
    output logic o_neg_fail = 1'b0,
    output logic [11:0] o_adc_data = 12'h000
);
    timeunit 1ns;
    timeprecision 1ps;
    int adc_wait = 0;
    // A conversion in flight is dropped on reset, so no stale result can
    // land after the sequencer restarts; the idle bus shows its inverse.
    always @(posedge i_mclk) begin
        if (i_rst || i_adc_start || adc_wait != 1) begin
            o_adc_done <= 1'b0;
            if (o_adc_done) o_adc_data <= ~o_adc_data;
        end else begin
            o_adc_done <= 1'b1;
            case (i_adc_channel)
                4'h0: o_adc_data <= i_vin;
                4'h1: o_adc_data <= i_isense;
                4'h8: o_adc_data <= REF_CODE;
                default: o_adc_data <= i_temp;
            endcase
        end
        if (i_rst) adc_wait <= 0;
        else if (i_adc_start) adc_wait <= $urandom_range(4, 1);
        else if (adc_wait != 0) adc_wait <= adc_wait - 1;
    end
    always @(posedge i_mclk) begin
        if (i_ping) begin
            repeat ($urandom_range(5, 1)) @(posedge i_mclk);
            o_det_done <= 1'b1;
            o_det_valid <= i_present;
            @(posedge i_mclk);
            o_det_done <= 1'b0;
            o_det_valid <= 1'b0;
            if (i_present) begin
                repeat ($urandom_range(6, 2)) @(posedge i_mclk);
                o_neg_done <= i_neg_ok;
                o_neg_fail <= !i_neg_ok;
                @(posedge i_mclk);
                o_neg_done <= 1'b0;
                o_neg_fail <= 1'b0;
            end
        end
    end
endmodule // rx_model

/* File: verif/tb_tx_fault_supervisor.sv */
// Self-checking bench for the fault supervisor with a receiver model.
// Assumes the shortened counts set on the instance below.
`include "tx_fault_supervisor_consts.vh"
module tb_tx_fault_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] REF = 12'h4b0;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, present = 1'b0, neg_ok = 1'b0;
    logic rv = 1'b0, adc_done, det_done, det_valid, neg_done, neg_fail;
    logic [1:0] rc = 2'h0;
    logic [11:0] ov_lim = `OV_LIMIT_RST, oc_lim = `OC_LIMIT_RST;
    logic [11:0] vin = 12'hfff, isense = 12'h000, temp = 12'h800, adc_data;
    wire adc_start, ping, pe, ovg, ocg, thg, slp, lnk, bz;
    wire [3:0] adc_ch;
    wire [2:0] state;
    wire [7:0] level;
    wire [11:0] ref_ch, tmp_ch;
    logic [10:0] exp_q[$];
    logic [10:0] seen = 11'h000;
    logic [7:0] lv = 8'h40;
    int errors = 0, n_compared = 0;
    always #4 i_mclk = ~i_mclk;
    tx_fault_supervisor #(.PING_CYCLES(20), .STARTUP_CYCLES(50),
        .BUZZ_CYCLES(10)) dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_ov_limit(ov_lim), .i_oc_limit(oc_lim), .i_adc_done(adc_done),
        .i_adc_data(adc_data), .i_detect_done(det_done),
        .i_detect_valid(det_valid), .i_negotiate_done(neg_done),
        .i_negotiate_fail(neg_fail), .i_req_valid(rv), .i_req_code(rc),
        .o_adc_start(adc_start), .o_adc_channel(adc_ch), .o_ping(ping),
        .o_power_enable(pe), .o_power_level(level), .o_sleep(slp),
        .o_link_up(lnk), .o_buzzer(bz), .o_overvoltage_guard(ovg),
        .o_overcurrent_guard(ocg), .o_thermal_shutdown(thg),
        .o_state(state), .o_reference_channel(ref_ch),
        .o_die_temp_channel(tmp_ch));
    rx_model #(.REF_CODE(REF)) far (.i_mclk(i_mclk), .i_rst(i_sys_rst),
        .i_present(present),
        .i_neg_ok(neg_ok), .i_adc_start(adc_start), .i_ping(ping),
        .i_vin(vin), .i_isense(isense), .i_temp(temp),
        .i_adc_channel(adc_ch), .o_adc_done(adc_done),
        .o_det_done(det_done), .o_det_valid(det_valid),
        .o_neg_done(neg_done), .o_neg_fail(neg_fail), .o_adc_data(adc_data));
    task automatic chk(input logic [11:0] got, input logic [11:0] want);
        n_compared++;
        if (got !== want) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic ex(input logic [2:0] s);
        exp_q.push_back({s, s == 3'h4 ? lv : 8'h00});
    endtask
    task automatic drain;
        int n = 0;
        while (exp_q.size() != 0 && n < 400) begin
            @(negedge i_mclk);
            n++;
        end
        if (exp_q.size() != 0) begin
            errors++;
            $display("[FAIL] %0t pending %h want %h", $time, exp_q.size(), 0);
        end
    endtask
    // Level is only compared in transfer, where the receiver steers it.
    always @(negedge i_mclk) begin
        if (i_sys_rst) seen = 11'h000;
        else if ({state, state == 3'h4 ? level : 8'h00} !== seen) begin
            seen = {state, state == 3'h4 ? level : 8'h00};
            chk({1'b0, seen},
                {1'b0, exp_q.size() != 0 ? exp_q.pop_front() : 11'h7ff});
        end
    end
    task automatic req(input logic [1:0] c);
        rv = 1'b1;
        rc = c;
        if (c == 2'h1 && lv != 8'hff) lv = lv + 8'h01;
        else if (c == 2'h2 && lv != 8'h00) lv = lv - 8'h01;
        else c = 2'h0;
        if (c != 2'h0) ex(3'h4);
        @(negedge i_mclk);
    endtask
    task automatic go(input logic p, input logic ok, input logic [11:0] sq);
        present = p;
        neg_ok = ok;
        for (int i = 8; i >= 0; i -= 4) begin
            if (sq[i+:4] == 4'h4) lv = 8'h40;
            if (sq[i+:4] != 4'h0) ex(sq[i+:3]);
        end
        drain();
    endtask
    task automatic end_of_test;
        errors += exp_q.size();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        errors++;
        $display("[FAIL] %0t timeout pending %h want %h", $time,
            exp_q.size(), 0);
        end_of_test();
    end
    initial begin
        void'($urandom(32'h4c0c));
        ov_lim = 12'($urandom_range(12'hf00, 12'h100));
        oc_lim = 12'($urandom_range(12'hf00, 12'h100));
        repeat (16) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        ex(3'h5);
        drain();
        repeat (60) @(negedge i_mclk);
        chk({11'h000, ovg}, 12'h001);
        i_sys_rst = 1'b1;
        vin = 12'($urandom_range(ov_lim, 0));
        repeat (4) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        ex(3'h1);
        drain();
        vin = 12'hfff;
        go(1'b0, 1'b1, 12'h021);
        go(1'b1, 1'b0, 12'h231);
        go(1'b1, 1'b1, 12'h234);
        @(negedge i_mclk);
        chk({10'h000, lnk, bz}, 12'h003);
        isense = 12'($urandom_range(oc_lim, 0));
        repeat (40) req(2'($urandom_range(3, 0)));
        repeat (200) req(2'h1);
        req(2'h3);
        repeat (260) req(2'h2);
        rv = 1'b0;
        chk({11'h000, ovg}, 12'h000);
        chk(ref_ch, REF);
        chk(tmp_ch, temp);
        isense = oc_lim + 12'h001;
        ex(3'h1);
        drain();
        chk({9'h000, ocg, pe, lnk}, 12'h004);
        isense = oc_lim;
        go(1'b1, 1'b1, 12'h021);
        go(1'b0, 1'b1, 12'h021);
        go(1'b1, 1'b1, 12'h234);
        chk({11'h000, ocg}, 12'h000);
        temp = 12'hc01;
        ex(3'h1);
        drain();
        repeat (60) @(negedge i_mclk);
        chk({9'h000, thg, pe, slp}, 12'h005);
        temp = 12'h9ff;
        go(1'b1, 1'b1, 12'h234);
        end_of_test();
    end
endmodule // tb_tx_fault_supervisor
